// ===== verilog/gpsmw_pkg.sv
// Constants and types shared by the PHY status and MMD window register slice
package gpsmw_pkg;
    // Register indices; the AHB byte address is four times the index
    localparam logic [5:0] IDX_GIG_STAT = 6'h0a;
    localparam logic [5:0] IDX_MMD_CTRL = 6'h0d;
    localparam logic [5:0] IDX_MMD_WIN = 6'h0e;
    localparam logic [5:0] IDX_GIG_ABIL = 6'h0f;
    localparam logic [5:0] IDX_FAST_EXT = 6'h10;
    localparam logic [5:0] IDX_GIG_EXT = 6'h11;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h1c;
    localparam logic [5:0] IDX_IRQ_EN = 6'h1d;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h1e;
    localparam logic [5:0] IDX_PAGE = 6'h1f;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 7;

    localparam logic [1:0] PAGE_MAX_SHARED = 2'h0 + 2'd2;
    localparam logic [1:0] PAGE_ZERO = 2'h0;

    // Field positions
    localparam int FUNC_MSB = 15;
    localparam int FUNC_LSB = 14;
    localparam int DEVAD_MSB = 4;
    localparam int PAGE_MSB = 1;
    localparam int IRQ_W = 4;
    localparam int MASTER_BIT = 14;

    localparam logic [15:0] CAP_VALUE = 16'h3000;
    localparam logic [7:0] IDLE_MAX = 8'hff;
    localparam logic [7:0] IDLE_ONE = 8'h01;
    localparam logic [15:0] WIN_ONE = 16'h0001;
    localparam logic [15:0] RST16 = 16'h0000;
    localparam logic [31:0] RST32 = 32'h0000_0000;
    localparam logic [1:0] OKAY = 2'h0;

    typedef enum logic [1:0] {
        FN_ADDR = 2'b00,
        FN_DATA = 2'b01,
        FN_DATA_INC_RW = 2'b10,
        FN_DATA_INC_WR = 2'b11
    } gpsmw_func_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_ACT = 2'b01,
        PH_DONE = 2'b10
    } gpsmw_phase_t;

    typedef struct packed {
        gpsmw_phase_t phase;
        logic [5:0] idx;
        logic cap_write;
        logic [1:0] page;
        logic ms_fault_latch;
        logic [7:0] idle_cnt;
        gpsmw_func_t func;
        logic [4:0] devad;
        logic [15:0] mmd_addr;
        logic [15:0] mmd_wdata;
        logic mmd_wr_strobe;
        logic [15:0] fast_sticky;
        logic [15:0] gig_sticky;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [31:0] hrdata;
    } gpsmw_state_t;
endpackage : gpsmw_pkg

// ===== verilog/gpsmw_regs.sv
// AHB-Lite register slice: gigabit status, MMD indirect window, status extensions
// How it works
// RULE1 - Config fault latches high until read
// RULE2 - Bit 14 shows master/slave resolution
// RULE3 - Bits 13, 12 show receiver health
// RULE4 - Bits 11, 10 show partner gigabit ability
// RULE5 - Idle error count, clears on read
// RULE6 - Two-bit selector picks window meaning
// RULE7 - Five-bit MMD device address, resets zero
// RULE8 - Writes through window never increment address
// RULE9 - Window is address in 00, else data
// RULE10 - Capability register reads fixed constant
// RULE11 - Live fast descrambler lock and link
// RULE12 - Sticky fast error flags clear on read
// RULE13 - Live gigabit descrambler lock and link
// RULE14 - Sticky gigabit error flags clear on read
// RULE15 - Legacy partner and crossover error bits
// RULE16 - Page decode: shared vs page zero
// RULE17 - Reserved bits read zero, ignore writes
// RULE18 - Read-increment mode 10 advances address after a read
`timescale 1ns/10ps
module gpsmw_regs
    import gpsmw_pkg::*;
(
    input wire logic CLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic [1:0] HRESP,
    input wire logic MS_FAULT,
    input wire logic MS_MASTER,
    input wire logic LOCAL_RX_OK,
    input wire logic REMOTE_RX_OK,
    input wire logic LP_1000_FD,
    input wire logic LP_1000_HD,
    input wire logic IDLE_ERR,
    input wire logic FAST_LOCKED,
    input wire logic FAST_LINK,
    input wire logic [5:0] FAST_EVT,
    input wire logic GIG_LOCKED,
    input wire logic GIG_LINK,
    input wire logic [6:0] GIG_EVT,
    input wire logic GIG_LEGACY_LP,
    input wire logic GIG_XOVER_ERR,
    output logic [4:0] MMD_DEVAD,
    output logic [15:0] MMD_ADDR,
    output logic [15:0] MMD_WDATA,
    output logic MMD_WR_STROBE,
    input wire logic [15:0] MMD_RDATA,
    output logic IRQ
);
    gpsmw_state_t r;
    gpsmw_state_t next_r;

    logic accept;
    logic act_rd;
    logic act_wr;
    logic page_shared;
    logic page_zero;
    logic [15:0] rd_val;
    logic [15:0] fast_set;
    logic [15:0] gig_set;
    logic [IRQ_W-1:0] irq_evt;

    assign accept = HSEL & HTRANS[1] & HREADY;
    assign act_rd = (r.phase == PH_ACT) & ~r.cap_write;
    assign act_wr = (r.phase == PH_ACT) & r.cap_write;
    // RULE16 page gating
    assign page_shared = r.page <= PAGE_MAX_SHARED;
    assign page_zero = r.page == PAGE_ZERO;

    // RULE12 fast event to bit positions
    assign fast_set = {1'b0, FAST_EVT[5:4], 1'b0, FAST_EVT[3:0], 8'h00};
    // RULE14 gigabit event to bit positions
    assign gig_set = {1'b0, GIG_EVT[6:5], 1'b0, GIG_EVT[4:0], 7'h00};
    assign irq_evt = {IDLE_ERR, |GIG_EVT, |FAST_EVT, MS_FAULT};

    // Read view of the addressed register
    always_comb begin
        rd_val = RST16;
        case (r.idx)
            IDX_GIG_STAT: begin
                // RULE2 RULE3 RULE4 status bits
                if (page_shared) begin
                    rd_val = {r.ms_fault_latch, MS_MASTER, LOCAL_RX_OK, REMOTE_RX_OK,
                              LP_1000_FD, LP_1000_HD, 2'b00, r.idle_cnt};
                end
            end
            IDX_MMD_CTRL: begin
                // RULE17 reserved bits zero
                if (page_shared) begin
                    rd_val = {r.func, 9'h000, r.devad};
                end
            end
            IDX_MMD_WIN: begin
                // RULE9 address or data view
                if (page_shared) begin
                    rd_val = (r.func == FN_ADDR) ? r.mmd_addr : MMD_RDATA;
                end
            end
            IDX_GIG_ABIL: begin
                // RULE10 fixed capability
                if (page_shared) begin
                    rd_val = CAP_VALUE;
                end
            end
            IDX_FAST_EXT: begin
                // RULE11 live lock and link
                if (page_zero) begin
                    rd_val = r.fast_sticky | {FAST_LOCKED, 2'b00, FAST_LINK, 12'h000};
                end
            end
            IDX_GIG_EXT: begin
                // RULE13 RULE15 live bits
                if (page_zero) begin
                    rd_val = r.gig_sticky | {GIG_LOCKED, 2'b00, GIG_LINK, 5'h00,
                                             GIG_LEGACY_LP, GIG_XOVER_ERR, 5'h00};
                end
            end
            IDX_IRQ_STAT: rd_val = {12'h000, r.irq_stat};
            IDX_IRQ_EN: rd_val = {12'h000, r.irq_en};
            IDX_PAGE: rd_val = {14'h0000, r.page};
            default: rd_val = RST16;
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.mmd_wr_strobe = 1'b0;
        case (r.phase)
            PH_IDLE: begin
                if (accept) begin
                    next_r.phase = PH_ACT;
                end
            end
            PH_ACT: begin
                next_r.phase = PH_DONE;
                if (r.cap_write) begin
                    case (r.idx)
                        IDX_MMD_CTRL: begin
                            if (page_shared) begin
                                // RULE6 selector write
                                next_r.func = gpsmw_func_t'(HWDATA[FUNC_MSB:FUNC_LSB]);
                                // RULE7 device address
                                next_r.devad = HWDATA[DEVAD_MSB:0];
                            end
                        end
                        IDX_MMD_WIN: begin
                            if (page_shared) begin
                                if (r.func == FN_ADDR) begin
                                    next_r.mmd_addr = HWDATA[15:0];
                                end else begin
                                    // RULE8 data write, address kept
                                    next_r.mmd_wdata = HWDATA[15:0];
                                    next_r.mmd_wr_strobe = 1'b1;
                                end
                            end
                        end
                        IDX_IRQ_EN: next_r.irq_en = HWDATA[IRQ_W-1:0];
                        IDX_IRQ_CLR: next_r.irq_stat = r.irq_stat & ~HWDATA[IRQ_W-1:0];
                        IDX_PAGE: next_r.page = HWDATA[PAGE_MSB:0];
                        default: next_r.page = r.page;
                    endcase
                end else begin
                    next_r.hrdata = {16'h0000, rd_val};
                    case (r.idx)
                        IDX_GIG_STAT: begin
                            if (page_shared) begin
                                // RULE1 read releases latch
                                next_r.ms_fault_latch = 1'b0;
                                // RULE5 clear on read
                                next_r.idle_cnt = 8'h00;
                            end
                        end
                        IDX_MMD_WIN: begin
                            // RULE18 read post-increment
                            if (page_shared && r.func == FN_DATA_INC_RW) begin
                                next_r.mmd_addr = r.mmd_addr + WIN_ONE;
                            end
                        end
                        IDX_FAST_EXT: begin
                            // RULE12 clear on read
                            if (page_zero) begin
                                next_r.fast_sticky = RST16;
                            end
                        end
                        IDX_GIG_EXT: begin
                            // RULE14 clear on read
                            if (page_zero) begin
                                next_r.gig_sticky = RST16;
                            end
                        end
                        default: next_r.hrdata = {16'h0000, rd_val};
                    endcase
                end
            end
            PH_DONE: begin
                next_r.phase = accept ? PH_ACT : PH_IDLE;
            end
            default: next_r.phase = PH_IDLE;
        endcase
        if (accept) begin
            next_r.idx = HADDR[IDX_MSB:IDX_LSB];
            next_r.cap_write = HWRITE;
        end
        // Sets come after clears so a coincident event is kept
        // RULE1 fault latch set
        next_r.ms_fault_latch = next_r.ms_fault_latch | MS_FAULT;
        // RULE5 saturating count
        if (IDLE_ERR && next_r.idle_cnt != IDLE_MAX) begin
            next_r.idle_cnt = next_r.idle_cnt + IDLE_ONE;
        end
        // RULE12 RULE14 sticky sets
        next_r.fast_sticky = next_r.fast_sticky | fast_set;
        next_r.gig_sticky = next_r.gig_sticky | gig_set;
        next_r.irq_stat = next_r.irq_stat | irq_evt;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // One wait state on every transfer keeps read data coherent with writes
    assign HREADYOUT = r.phase != PH_ACT;
    assign HRESP = OKAY;
    assign HRDATA = r.hrdata;
    assign MMD_DEVAD = r.devad;
    assign MMD_ADDR = r.mmd_addr;
    assign MMD_WDATA = r.mmd_wdata;
    assign MMD_WR_STROBE = r.mmd_wr_strobe;
    assign IRQ = |(r.irq_stat & r.irq_en);

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    // RULE1 fault latch sets
    AST_FAULT_LATCH: assert property (MS_FAULT |=> r.ms_fault_latch) // RULE1
        else $error("fault latch not set");
    // RULE1 latch holds until read
    AST_FAULT_HOLD: assert property (r.ms_fault_latch && !act_rd // RULE1
        |=> r.ms_fault_latch)
        else $error("fault latch dropped");
    // RULE2 master bit
    AST_MASTER_BIT: assert property (act_rd && r.idx == IDX_GIG_STAT && page_shared
        |=> HRDATA[MASTER_BIT] == $past(MS_MASTER)) // RULE2
        else $error("master bit wrong");
    // RULE3 RULE4 whole status word
    AST_STAT_WORD: assert property (act_rd && r.idx == IDX_GIG_STAT && page_shared // RULE4
        |=> HRDATA == {16'h0000, $past(r.ms_fault_latch), $past(MS_MASTER),
        $past(LOCAL_RX_OK), $past(REMOTE_RX_OK), $past(LP_1000_FD), $past(LP_1000_HD),
        2'b00, $past(r.idle_cnt)})
        else $error("status word wrong");
    // RULE5 read clears count
    AST_IDLE_CLR: assert property (act_rd && r.idx == IDX_GIG_STAT && page_shared
        && !IDLE_ERR |=> r.idle_cnt == 8'h00) // RULE5
        else $error("idle count not cleared");
    // RULE5 count steps by one
    AST_IDLE_INC: assert property (IDLE_ERR && r.idle_cnt != IDLE_MAX && !act_rd // RULE5
        |=> r.idle_cnt == $past(r.idle_cnt) + IDLE_ONE)
        else $error("idle count not advanced");
    // RULE5 count saturates
    AST_IDLE_SAT: assert property (r.idle_cnt == IDLE_MAX && !act_rd // RULE5
        |=> r.idle_cnt == IDLE_MAX)
        else $error("idle count wrapped");
    // RULE6 selector takes write
    AST_FUNC_WR: assert property (act_wr && r.idx == IDX_MMD_CTRL && page_shared // RULE6
        |=> r.func == $past(HWDATA[FUNC_MSB:FUNC_LSB]))
        else $error("selector not written");
    // RULE7 device address takes write
    AST_DEVAD_WR: assert property (act_wr && r.idx == IDX_MMD_CTRL && page_shared // RULE7
        |=> MMD_DEVAD == $past(HWDATA[DEVAD_MSB:0]))
        else $error("device address not written");
    // RULE9 address mode write
    AST_ADDR_WR: assert property (act_wr && r.idx == IDX_MMD_WIN && page_shared // RULE9
        && r.func == FN_ADDR |=> MMD_ADDR == 16'($past(HWDATA)))
        else $error("window address not written");
    // RULE9 data mode read
    AST_WIN_RD: assert property (act_rd && r.idx == IDX_MMD_WIN && page_shared // RULE9
        && r.func != FN_ADDR |=> HRDATA == {16'h0000, $past(MMD_RDATA)})
        else $error("window data read wrong");
    // RULE18 read increment
    AST_WIN_INC: assert property (act_rd && r.idx == IDX_MMD_WIN && page_shared
        && r.func == FN_DATA_INC_RW |=> r.mmd_addr == $past(r.mmd_addr) + WIN_ONE) // RULE18
        else $error("no read increment");
    // RULE18 other modes keep address
    AST_NO_RD_INC: assert property (act_rd && r.func != FN_DATA_INC_RW // RULE18
        |=> $stable(r.mmd_addr))
        else $error("address moved on read");
    // RULE8 write keeps address
    AST_NO_WR_INC: assert property (act_wr && r.idx == IDX_MMD_WIN && page_shared
        && r.func != FN_ADDR |=> $stable(r.mmd_addr) && MMD_WR_STROBE) // RULE8
        else $error("write changed address");
    // RULE8 strobe lasts one cycle
    AST_STROBE_ONE: assert property (MMD_WR_STROBE // RULE8
        |=> !MMD_WR_STROBE)
        else $error("strobe too long");
    // RULE10 fixed capability
    AST_CAP: assert property (act_rd && r.idx == IDX_GIG_ABIL && page_shared
        |=> HRDATA == {16'h0000, CAP_VALUE}) // RULE10
        else $error("capability wrong");
    // RULE12 fast flag sets
    AST_FAST_STICKY: assert property (FAST_EVT[0] |=> r.fast_sticky[8]) // RULE12
        else $error("fast flag lost");
    // RULE12 fast flags clear on read
    AST_FAST_CLR: assert property (act_rd && r.idx == IDX_FAST_EXT && page_zero // RULE12
        && FAST_EVT == 6'h00 |=> r.fast_sticky == RST16)
        else $error("fast flags not cleared");
    // RULE14 gigabit flag sets
    AST_GIG_STICKY: assert property (GIG_EVT[0] |=> r.gig_sticky[7]) // RULE14
        else $error("gigabit flag lost");
    // RULE14 gigabit flags clear on read
    AST_GIG_CLR: assert property (act_rd && r.idx == IDX_GIG_EXT && page_zero // RULE14
        && GIG_EVT == 7'h00 |=> r.gig_sticky == RST16)
        else $error("gigabit flags not cleared");
    // RULE16 fast extension page zero only
    AST_PAGE_GATE: assert property (act_rd && r.idx == IDX_FAST_EXT && !page_zero
        |=> HRDATA == RST32) // RULE16
        else $error("page gate failed");
    // RULE16 gigabit extension page zero only
    AST_GIG_PAGE: assert property (act_rd && r.idx == IDX_GIG_EXT && !page_zero // RULE16
        |=> HRDATA == RST32)
        else $error("gigabit page gate failed");
    // RULE16 shared pages only
    AST_ABIL_PAGE: assert property (act_rd && r.idx == IDX_GIG_ABIL && !page_shared // RULE16
        |=> HRDATA == RST32)
        else $error("shared page gate failed");
    // RULE17 read-only write ignored
    AST_RO_IGNORED: assert property (act_wr && r.idx == IDX_GIG_ABIL // RULE17
        |=> $stable(r.func) && $stable(r.devad) && $stable(r.page))
        else $error("read-only write took effect");
    // Interrupt status keeps every event
    AST_IRQ_STICKY: assert property (irq_evt != '0
        |=> (r.irq_stat & $past(irq_evt)) == $past(irq_evt))
        else $error("interrupt event lost");
    // One wait state per transfer
    AST_WAIT_STATE: assert property (accept |=> !HREADYOUT ##1 HREADYOUT)
        else $error("wait state wrong");
endmodule : gpsmw_regs

// ===== test/tb_top.sv
// Self-checking bench for the PHY status and MMD window register slice
`timescale 1ns/10ps
module tb_top
    import gpsmw_pkg::*;
;
    logic CLK = 0, SRST = 1, HSEL = 0, HWRITE = 0, HREADY, HREADYOUT, IRQ, MMD_WR_STROBE;
    logic [1:0] HTRANS = 2'h0, HRESP;
    logic [31:0] HADDR = 32'h0000_0000, HWDATA = 32'h0000_0000, HRDATA, rd;
    logic [31:0] seed = 32'h76a0_9142;
    logic MS_FAULT = 0, MS_MASTER = 0, LOCAL_RX_OK = 0, REMOTE_RX_OK = 0, LP_1000_FD = 0;
    logic LP_1000_HD = 0, IDLE_ERR = 0, FAST_LOCKED = 0, FAST_LINK = 0, GIG_LOCKED = 0;
    logic GIG_LINK = 0, GIG_LEGACY_LP = 0, GIG_XOVER_ERR = 0;
    logic [5:0] FAST_EVT = 6'h00;
    logic [6:0] GIG_EVT = 7'h00;
    logic [4:0] MMD_DEVAD;
    logic [15:0] MMD_ADDR, MMD_WDATA, MMD_RDATA = 16'h0000, a;
    int error_cnt = 0, num_checks = 0;
    // Single slave, so its ready is the bus ready
    assign HREADY = HREADYOUT;
    always #5 CLK = ~CLK;

    gpsmw_regs gpsmw_regs_i (.CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .MS_FAULT(MS_FAULT),
        .MS_MASTER(MS_MASTER), .LOCAL_RX_OK(LOCAL_RX_OK), .REMOTE_RX_OK(REMOTE_RX_OK),
        .LP_1000_FD(LP_1000_FD), .LP_1000_HD(LP_1000_HD), .IDLE_ERR(IDLE_ERR),
        .FAST_LOCKED(FAST_LOCKED), .FAST_LINK(FAST_LINK), .FAST_EVT(FAST_EVT),
        .GIG_LOCKED(GIG_LOCKED), .GIG_LINK(GIG_LINK), .GIG_EVT(GIG_EVT),
        .GIG_LEGACY_LP(GIG_LEGACY_LP), .GIG_XOVER_ERR(GIG_XOVER_ERR), .MMD_DEVAD(MMD_DEVAD),
        .MMD_ADDR(MMD_ADDR), .MMD_WDATA(MMD_WDATA), .MMD_WR_STROBE(MMD_WR_STROBE),
        .MMD_RDATA(MMD_RDATA), .IRQ(IRQ));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait for ready; a hang ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (HREADY !== 1'b1 && n < 100);
        if (HREADY !== 1'b1) begin
            error_cnt++;
            wrap_up();
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, idx, 2'h0};
        HWRITE <= w;
        wait_rdy();
        HTRANS <= 2'h0;
        HSEL <= 1'b0;
        HWDATA <= wd;
        wait_rdy();
        rd = HRDATA;
    endtask : bus

    task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        chk({30'h0, HRESP}, 32'h0000_0000);
        chk(rd, exp);
    endtask : rchk

    task automatic pulse_evt(input logic [5:0] f, input logic [6:0] g, input logic ie);
        FAST_EVT <= f;
        GIG_EVT <= g;
        IDLE_ERR <= ie;
        @(posedge CLK);
        FAST_EVT <= 6'h00;
        GIG_EVT <= 7'h00;
        IDLE_ERR <= 1'b0;
        @(posedge CLK);
    endtask : pulse_evt

    initial begin
        repeat (16) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        rchk(IDX_GIG_STAT, 32'h0000_0000);
        rchk(IDX_MMD_CTRL, 32'h0000_0000);
        rchk(IDX_MMD_WIN, 32'h0000_0000);
        rchk(IDX_GIG_ABIL, 32'h0000_3000);
        rchk(6'h3f, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            {MS_MASTER, LOCAL_RX_OK, REMOTE_RX_OK, LP_1000_FD, LP_1000_HD} <= seed[4:0];
            {FAST_LOCKED, FAST_LINK, GIG_LOCKED, GIG_LINK} <= seed[10:7];
            {GIG_LEGACY_LP, GIG_XOVER_ERR} <= seed[6:5];
            MMD_RDATA <= seed[31:16];
            pulse_evt(seed[22:17], seed[29:23], 1'b0);
            repeat (seed[14:12]) pulse_evt(6'h00, 7'h00, 1'b1);
            rchk(IDX_GIG_STAT, {17'h0, seed[4:0], 7'h0, seed[14:12]});
            rchk(IDX_GIG_STAT, {17'h0, seed[4:0], 10'h0});
            rchk(IDX_FAST_EXT, {16'h0, seed[10], seed[22:21], seed[9], seed[20:17],
                8'h0});
            rchk(IDX_FAST_EXT, {16'h0, seed[10], 2'b0, seed[9], 12'h0});
            rchk(IDX_GIG_EXT, {16'h0, seed[8], seed[29:28], seed[7], seed[27:23],
                seed[6:5], 5'h0});
            rchk(IDX_GIG_EXT, {16'h0, seed[8], 2'b0, seed[7], 5'h0, seed[6:5], 5'h0});
        end
        MS_FAULT <= 1'b1;
        @(posedge CLK);
        MS_FAULT <= 1'b0;
        @(posedge CLK);
        bus(1'b0, IDX_GIG_STAT, 32'h0000_0000);
        chk({31'h0, rd[15]}, 32'h0000_0001);
        bus(1'b0, IDX_GIG_STAT, 32'h0000_0000);
        chk({31'h0, rd[15]}, 32'h0000_0000);
        // Junk in reserved bits must not stick
        seed = lfsr(seed);
        bus(1'b1, IDX_MMD_CTRL, {seed[31:16], 2'b00, seed[13:0]});
        rchk(IDX_MMD_CTRL, {27'h0, seed[4:0]});
        chk({27'h0, MMD_DEVAD}, {27'h0, seed[4:0]});
        a = seed[31:16];
        bus(1'b1, IDX_MMD_WIN, {16'hffff, a});
        chk({16'h0, MMD_ADDR}, {16'h0, a});
        chk({31'h0, MMD_WR_STROBE}, 32'h0000_0000);
        rchk(IDX_MMD_WIN, {16'h0, a});
        for (int f = 1; f < 4; f++) begin
            bus(1'b1, IDX_MMD_CTRL, {16'h0, 2'(f), 14'h0});
            bus(1'b1, IDX_MMD_WIN, {16'h0, ~a});
            chk({MMD_WDATA, MMD_ADDR}, {~a, a});
            chk({31'h0, MMD_WR_STROBE}, 32'h0000_0001);
            rchk(IDX_MMD_WIN, {16'h0, MMD_RDATA});
            @(posedge CLK);
            if (f == 2) begin
                a = a + 16'h0001;
            end
            chk({16'h0, MMD_ADDR}, {16'h0, a});
        end
        // Page 3 hides all paged registers, pages above 0 hide the extensions
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, IDX_PAGE, 32'(p));
            rchk(IDX_GIG_ABIL, (p < 3) ? 32'h0000_3000 : 32'h0000_0000);
            rchk(IDX_GIG_EXT, (p == 0) ? {16'h0, GIG_LOCKED, 2'b0, GIG_LINK, 5'h0,
                GIG_LEGACY_LP, GIG_XOVER_ERR, 5'h0} : 32'h0000_0000);
        end
        bus(1'b1, IDX_PAGE, 32'h0000_0000);
        // Interrupt raise, mask and clear
        bus(1'b1, IDX_IRQ_CLR, 32'h0000_000f);
        bus(1'b1, IDX_IRQ_EN, 32'h0000_0002);
        chk({31'h0, IRQ}, 32'h0000_0000);
        pulse_evt(6'h01, 7'h01, 1'b0);
        chk({31'h0, IRQ}, 32'h0000_0001);
        rchk(IDX_IRQ_STAT, 32'h0000_0006);
        bus(1'b1, IDX_IRQ_CLR, 32'h0000_0002);
        chk({31'h0, IRQ}, 32'h0000_0000);
        rchk(IDX_IRQ_STAT, 32'h0000_0004);
        rchk(IDX_IRQ_EN, 32'h0000_0002);
        wrap_up();
    end
endmodule : tb_top
